/* File: hw/fspg_defs.svh */
/*
 flash self-program guard constants: register offsets, field positions,
 reset values and timing counts.
 assumes inclusion by bare name from the modules and the bench.
*/
`ifndef FSPG_DEFS_SVH
`define FSPG_DEFS_SVH

// register word offsets (byte addresses, one 32-bit word each)
`define FSPG_REG_CTRL 8'h00
`define FSPG_REG_LOCK 8'h04
`define FSPG_REG_STAT 8'h08
`define FSPG_REG_CFG 8'h0c

// control register fields
`define FSPG_CTRL_ENABLE 0
`define FSPG_CTRL_REEN 1
`define FSPG_CTRL_LOCKSET 2
`define FSPG_CTRL_CHIPERASE 3

// lock register fields (app field in [1:0], boot field in [3:2])
`define FSPG_LOCK_APP_LO 0
`define FSPG_LOCK_APP_HI 1
`define FSPG_LOCK_BOOT_LO 2
`define FSPG_LOCK_BOOT_HI 3
`define FSPG_LOCK_RESET 4'hf

// config register fields
`define FSPG_CFG_VEC_BOOT 0
`define FSPG_CFG_PROG_MODE 1

// status register fields
`define FSPG_STAT_BUSY 0
`define FSPG_STAT_HALT 1
`define FSPG_STAT_ACTIVE 2
`define FSPG_STAT_REJECT 3
`define FSPG_STAT_ENABLE 4

// arming window of the enable, in instruction-issue cycles
`define FSPG_ARM_CYCLES 3'h4

`endif

/* File: hw/fspg_pkg.sv */
/*
 flash self-program guard types.
 assumes fspg_defs.svh sits on the include path.
*/
package fspg_pkg;
   // kind of program-memory request from the cpu core
   typedef enum logic [1:0] {
      FSPG_OP_LOAD,
      FSPG_OP_ERASE,
      FSPG_OP_WRITE,
      FSPG_OP_PAGELOAD
   } fspg_op_t;

   // one program-memory instruction issued by the cpu core
   typedef struct packed {
      logic valid;
      fspg_op_t op;
      logic [15:0] exec_addr;
      logic [15:0] target_addr;
   } fspg_req_t;

   // decisions handed back to the core and to the flash macro
   typedef struct packed {
      logic start;
      logic start_halting;
      logic load_ok;
      logic load_blocked;
   } fspg_grant_t;
endpackage : fspg_pkg

/* File: hw/fspg_section_dec.sv */
/*
 section decoder: classifies one flash word address as boot or
 application section and as halting or read-during-write section.
 assumes word addresses and a boot size code from the fuses.
*/
`timescale 1ns/1ps
`include "fspg_defs.svh"

module fspg_section_dec
   import fspg_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int HALT_LIMIT = 3072
) (
   // fuse setting and address under test
   input wire logic [1:0] boot_size_fuses,
   input wire logic [ADDR_W-1:0] addr,
   // classification
   output logic in_boot,
   output logic in_halting
);
   // boot start for each fuse code; the largest boot size must still
   // sit at or above HALT_LIMIT so boot stays inside the halting section
   function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] f);
      logic [ADDR_W:0] top;
      top = (ADDR_W+1)'(1) << ADDR_W;
      case (f)
         2'h3: boot_start = ADDR_W'(top - (ADDR_W+1)'(128));
         2'h2: boot_start = ADDR_W'(top - (ADDR_W+1)'(256));
         2'h1: boot_start = ADDR_W'(top - (ADDR_W+1)'(512));
         default: boot_start = ADDR_W'(top - (ADDR_W+1)'(1024));
      endcase
   endfunction : boot_start

   // boundary placed by fuses, halting limit fixed
   assign in_boot = addr >= boot_start(boot_size_fuses);
   assign in_halting = in_boot || (addr >= ADDR_W'(HALT_LIMIT));
endmodule : fspg_section_dec

/* File: hw/fspg_guard.sv */
/*
 flash self-program guard: decides whether store-program requests may
 start an erase or write, whether program loads may read across
 sections, stalls the cpu for halting-section operations, and keeps the
 section busy flag. registers reached over classic wishbone.
 assumes the flash macro reports completion with flash_done and that the
 cpu core presents one request per cycle on req.
*/
// Behaviour
// - no programming started from application code
// - boot code may program any page
// - fuses place boundary; separate lock fields
// - read-during-write operation keeps cpu running
// - halting-section operation stalls cpu throughout
// - boot section always inside halting section
// - busy flag reads one while blocked
// - busy set on busy-section start; cleared by reenable/pageload
// - locks set by software; chip erase clears
// - general lock modes ignore self programming
// - app lock 11: no app restriction
// - app lock 10/00 blocks app programming
// - app lock 00/01 blocks boot loads
// - app lock 00/01 masks interrupts in app
// - boot lock 11: no boot restriction
// - boot lock 10/00 blocks boot programming
// - boot lock 00/01 blocks app loads
// - boot lock 00/01 masks interrupts in boot
`timescale 1ns/1ps
`include "fspg_defs.svh"

module fspg_guard
   import fspg_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int HALT_LIMIT = 3072
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // fuses and general memory lock (the latter deliberately unused)
   input wire logic [1:0] boot_size_fuses,
   input wire logic [1:0] mem_lock_mode,
   // cpu core side
   input wire fspg_req_t req,
   input wire logic [ADDR_W-1:0] pc_addr,
   output fspg_grant_t grant,
   output logic cpu_halt,
   output logic irq_mask,
   // flash macro side
   input wire logic flash_done,
   output logic [ADDR_W-1:0] flash_page_addr
);
   typedef enum {ST_IDLE, ST_RUN_BUSY, ST_RUN_HALT} fspg_state_t;

   fspg_state_t state_q;
   logic [3:0] lock_q;
   logic [1:0] cfg_q;
   logic [2:0] arm_cnt_q;
   logic reen_q;
   logic busy_q;
   logic reject_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [ADDR_W-1:0] page_q;
   logic [1:0] app_lock_field;
   logic [1:0] boot_lock_field;
   logic exec_boot, exec_halting, tgt_boot, tgt_halting, pc_boot, pc_halting;
   logic armed, is_prog, prog_ok, prog_start, wr_stb, rd_stb;
   logic load_ok, pageload_go;

   // section decode of executing, target and current fetch address
   fspg_section_dec #(.ADDR_W(ADDR_W), .HALT_LIMIT(HALT_LIMIT)) u_dec_exec (
      .boot_size_fuses(boot_size_fuses),
      .addr(req.exec_addr[ADDR_W-1:0]),
      .in_boot(exec_boot),
      .in_halting(exec_halting)
   );
   fspg_section_dec #(.ADDR_W(ADDR_W), .HALT_LIMIT(HALT_LIMIT)) u_dec_tgt (
      .boot_size_fuses(boot_size_fuses),
      .addr(req.target_addr[ADDR_W-1:0]),
      .in_boot(tgt_boot),
      .in_halting(tgt_halting)
   );
   fspg_section_dec #(.ADDR_W(ADDR_W), .HALT_LIMIT(HALT_LIMIT)) u_dec_pc (
      .boot_size_fuses(boot_size_fuses),
      .addr(pc_addr),
      .in_boot(pc_boot),
      .in_halting(pc_halting)
   );

   // separate lock fields, one per section
   assign app_lock_field =
      lock_q[`FSPG_LOCK_APP_HI:`FSPG_LOCK_APP_LO];
   assign boot_lock_field =
      lock_q[`FSPG_LOCK_BOOT_HI:`FSPG_LOCK_BOOT_LO];

   // write protection: lower bit programmed (codes 10 and 00)
   function automatic logic wr_locked(input logic [1:0] f);
      wr_locked = !f[0];
   endfunction : wr_locked

   // read protection: upper bit programmed (codes 01 and 00)
   function automatic logic rd_locked(input logic [1:0] f);
      rd_locked = (f == 2'h0) || (f == 2'h1);
   endfunction : rd_locked

   // bus strobes; one-cycle ack so a held request is seen once
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
   assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

   assign armed = arm_cnt_q != 3'h0;
   assign is_prog = req.valid &&
      ((req.op == FSPG_OP_ERASE) || (req.op == FSPG_OP_WRITE));

   // permission for erase or write; mem_lock_mode plays no part
   always_comb begin
      prog_ok = armed && (state_q == ST_IDLE) && !reen_q;
      if (!exec_boot) begin
         prog_ok = 1'b0;
      end else if (tgt_boot) begin
         // boot code may rewrite the boot section itself
         prog_ok = prog_ok && !wr_locked(boot_lock_field);
      end else begin
         prog_ok = prog_ok && !wr_locked(app_lock_field);
      end
   end

   assign prog_start = is_prog && prog_ok;
   assign pageload_go = req.valid && armed && (req.op == FSPG_OP_PAGELOAD);

   // load permission; cross-section reads gated by the target's lock
   always_comb begin
      load_ok = 1'b1;
      if (busy_q && !tgt_halting) begin
         load_ok = 1'b0;
      end else if (exec_boot && !tgt_boot) begin
         load_ok = !rd_locked(app_lock_field);
      end else if (!exec_boot && tgt_boot) begin
         load_ok = !rd_locked(boot_lock_field);
      end
   end

   assign grant.start = prog_start;
   assign grant.start_halting = prog_start && tgt_halting;
   assign grant.load_ok = req.valid && (req.op == FSPG_OP_LOAD) && load_ok;
   assign grant.load_blocked = req.valid && (req.op == FSPG_OP_LOAD) &&
      !load_ok;

   // halting operation stalls the core, busy-section operation does not
   assign cpu_halt = (state_q == ST_RUN_HALT);

   // interrupts held off when vectors sit outside the read-protected section that is executing
   always_comb begin
      irq_mask = 1'b0;
      if (cfg_q[`FSPG_CFG_VEC_BOOT] && !pc_boot) begin
         irq_mask = rd_locked(app_lock_field);
      end else if (!cfg_q[`FSPG_CFG_VEC_BOOT] && pc_boot) begin
         irq_mask = rd_locked(boot_lock_field);
      end
   end

   assign flash_page_addr = page_q;

   // operation sequencer; a rejected request never leaves idle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (prog_start && tgt_halting) begin
                  state_q <= ST_RUN_HALT;
               end else if (prog_start) begin
                  state_q <= ST_RUN_BUSY;
               end
            end
            ST_RUN_BUSY: begin
               if (flash_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_RUN_HALT: begin
               if (flash_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // page address latched at start, so the core may reuse its pointer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         page_q <= '0;
      end else if (prog_start) begin
         page_q <= req.target_addr[ADDR_W-1:0];
      end
   end

   // enable window: armed for a few cycles, cleared by the next request
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         arm_cnt_q <= 3'h0;
      end else if (wr_stb && wb_adr_i == `FSPG_REG_CTRL && wb_sel_i[0] &&
                   wb_dat_i[`FSPG_CTRL_ENABLE]) begin
         arm_cnt_q <= `FSPG_ARM_CYCLES;
      end else if (req.valid && armed) begin
         arm_cnt_q <= 3'h0;
      end else if (armed) begin
         arm_cnt_q <= arm_cnt_q - 3'h1;
      end
   end

   // re-enable request rides on the same enable window
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reen_q <= 1'b0;
      end else if (wr_stb && wb_adr_i == `FSPG_REG_CTRL && wb_sel_i[0]) begin
         reen_q <= wb_dat_i[`FSPG_CTRL_REEN] && wb_dat_i[`FSPG_CTRL_ENABLE];
      end else if ((req.valid && armed) || arm_cnt_q == 3'h1) begin
         reen_q <= 1'b0;
      end
   end

   // busy flag: a start wins over any clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (prog_start && !tgt_halting) begin
         busy_q <= 1'b1;
      end else if (pageload_go && state_q == ST_IDLE) begin
         busy_q <= 1'b0;
      end else if (reen_q && req.valid && armed && state_q == ST_IDLE) begin
         busy_q <= 1'b0;
      end
   end

   // rejected programming is recorded and otherwise closes the enable window, also clearing busy if a re-enable is pending in idle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reject_q <= 1'b0;
      end else if (is_prog && !prog_ok) begin
         reject_q <= 1'b1;
      end else if (wr_stb && wb_adr_i == `FSPG_REG_STAT && wb_sel_i[0] &&
                   wb_dat_i[`FSPG_STAT_REJECT]) begin
         reject_q <= 1'b0;
      end
   end

   // lock bits: software or programming mode may only program (clear)
   // bits; only a chip erase or sys_rst restores the unprogrammed state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lock_q <= `FSPG_LOCK_RESET;
      end else if (wr_stb && wb_adr_i == `FSPG_REG_CTRL && wb_sel_i[0] &&
                   wb_dat_i[`FSPG_CTRL_CHIPERASE] &&
                   cfg_q[`FSPG_CFG_PROG_MODE]) begin
         lock_q <= `FSPG_LOCK_RESET;
      end else if (wr_stb && wb_adr_i == `FSPG_REG_LOCK && wb_sel_i[0] &&
                   (cfg_q[`FSPG_CFG_PROG_MODE] || exec_boot)) begin
         lock_q <= lock_q & wb_dat_i[3:0];
      end
   end

   // configuration: vector placement and programming-mode strap
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_q <= 2'h0;
      end else if (wr_stb && wb_adr_i == `FSPG_REG_CFG && wb_sel_i[0]) begin
         cfg_q <= wb_dat_i[1:0];
      end
   end

   // read mux; unmapped addresses read zero and still ack
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dat_q <= 32'h0;
      end else if (rd_stb) begin
         if (wb_adr_i == `FSPG_REG_CTRL) begin
            dat_q <= {28'h0, 2'h0, reen_q, armed};
         end else if (wb_adr_i == `FSPG_REG_LOCK) begin
            dat_q <= {28'h0, lock_q};
         end else if (wb_adr_i == `FSPG_REG_STAT) begin
            dat_q <= {27'h0, armed || state_q != ST_IDLE, reject_q,
                      state_q != ST_IDLE, cpu_halt, busy_q};
         end else if (wb_adr_i == `FSPG_REG_CFG) begin
            dat_q <= {30'h0, cfg_q};
         end else begin
            dat_q <= 32'h0;
         end
      end
   end

   // single-cycle acknowledge, dropped the cycle after
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule : fspg_guard

/* File: tb/fspg_guard_properties.sv */
/*
 port checker for the flash self-program guard.
 assumes it is bound into every fspg_guard instance.
*/
`timescale 1ns/1ps

module fspg_guard_chk
   import fspg_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int HALT_LIMIT = 3072
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // fuses and core side
   input wire logic [1:0] boot_size_fuses,
   input wire fspg_req_t req,
   input wire fspg_grant_t grant,
   input wire logic cpu_halt,
   // flash macro side
   input wire logic flash_done,
   input wire logic [ADDR_W-1:0] flash_page_addr
);
   logic prog;
   logic boot;
   logic [ADDR_W-1:0] tgt;
   // boot section grows down from the top as the fuse code falls
   assign prog = req.valid && req.op inside {FSPG_OP_ERASE, FSPG_OP_WRITE};
   assign tgt = req.target_addr[ADDR_W-1:0];
   assign boot = int'(req.exec_addr[ADDR_W-1:0]) >=
      (1 << ADDR_W) - (128 << (3 - int'(boot_size_fuses)));

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   app_code_refused_a:
      assert property (prog && !boot |-> !grant.start)
      else $error("start granted to application code");
   halting_target_a:
      assert property (grant.start |->
         grant.start_halting == (int'(tgt) >= HALT_LIMIT))
      else $error("halting section decode wrong");
   halt_starts_a:
      assert property (grant.start_halting |=> cpu_halt)
      else $error("no stall for halting page");
   halt_holds_a:
      assert property (cpu_halt && !flash_done |=> cpu_halt)
      else $error("stall dropped before completion");
   rww_runs_a:
      assert property (grant.start && !grant.start_halting |=> !cpu_halt[*2])
      else $error("stall on busy-section page");
   page_latch_a:
      assert property (grant.start |=> flash_page_addr == $past(tgt))
      else $error("page address not latched");
   reject_quiet_a:
      assert property (prog && !grant.start && !cpu_halt |=> !cpu_halt)
      else $error("refused request stalled core");
   load_one_a:
      assert property (req.valid && req.op == FSPG_OP_LOAD |->
         grant.load_ok ^ grant.load_blocked)
      else $error("load both or neither granted");
endmodule : fspg_guard_chk

bind fspg_guard fspg_guard_chk #(.ADDR_W(ADDR_W), .HALT_LIMIT(HALT_LIMIT))
   i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .boot_size_fuses(boot_size_fuses), .req(req), .grant(grant),
   .cpu_halt(cpu_halt), .flash_done(flash_done),
   .flash_page_addr(flash_page_addr));

/* File: tb/fspg_flash_model.sv */
/*
 flash macro stand-in: ends each started operation after a delay.
 assumes the bench sets the delay to two cycles or more.
*/
`timescale 1ns/1ps

module fspg_flash_model
   import fspg_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // guard side
   input wire fspg_grant_t grant,
   input wire logic [7:0] busy_cycles,
   output logic flash_done
);
   logic [7:0] cnt_q;
   // count down from the start; a slow delay exposes early releases
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= 8'h00;
         flash_done <= 1'b0;
      end else begin
         flash_done <= cnt_q == 8'h01;
         cnt_q <= grant.start ? busy_cycles : cnt_q - 8'(cnt_q != 8'h00);
      end
   end
endmodule : fspg_flash_model

/* File: tb/tb_flash_self_program_guard.sv */
/*
 bench of the guard: bus master, core requests, flash stand-in.
 assumes the guard, its checker and the flash model are compiled first.
*/
`timescale 1ns/1ps
`include "fspg_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
$display("mismatch %0t got %h want %h", $time, a, b); end end

module tb_flash_self_program_guard
   import fspg_pkg::*;
;
   logic core_clk, sys_rst, cyc, stb, we, ack, halt, irq, done;
   logic [7:0] adr, dly;
   logic [3:0] sel;
   logic [31:0] dat, rdat, rd;
   logic [1:0] fuse, mlock;
   logic [11:0] pc, page;
   fspg_req_t req;
   fspg_grant_t grant, g;
   int miscompares, checked, cycles;

   fspg_guard i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .boot_size_fuses(fuse), .mem_lock_mode(mlock), .req(req),
      .pc_addr(pc), .grant(grant), .cpu_halt(halt), .irq_mask(irq),
      .flash_done(done), .flash_page_addr(page));
   fspg_flash_model i_flash (.core_clk(core_clk), .sys_rst(sys_rst),
      .grant(grant), .busy_cycles(dly), .flash_done(done));

   // clock and hang guard
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   task automatic results();
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      do @(posedge core_clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
      wb(1'b0, a, 32'h0);
      `CHK(rd & m, e);
   endtask : rchk

   // one core request; the grant is combinational, so look mid-cycle
   task automatic op(input fspg_op_t o, input logic [11:0] e, t);
      @(posedge core_clk);
      req <= '{1'b1, o, {4'h0, e}, {4'h0, t}};
      @(negedge core_clk);
      g = grant;
      @(posedge core_clk);
      req.valid <= 1'b0;
      @(negedge core_clk);
   endtask : op

   task automatic wait_idle();
      for (int i = 0; i < 80 && halt !== 1'b0; i++) @(posedge core_clk);
      `CHK(halt, 1'b0);
   endtask : wait_idle

   task automatic t_reset();
      rchk(`FSPG_REG_LOCK, 32'hf, 32'hf);
      rchk(`FSPG_REG_STAT, 32'hf, 32'h0);
      rchk(8'h10, 32'hffffffff, 32'h0);
   endtask : t_reset

   // each fuse code: last app word refused, first boot word programs
   task automatic t_fuses();
      int b;
      for (int f = 0; f < 4; f++) begin
         fuse <= 2'(f);
         mlock <= 2'(f);
         b = 4096 - (128 << (3 - f));
         wb(1'b1, `FSPG_REG_CTRL, 32'h1);
         op(FSPG_OP_ERASE, 12'(b - 1), 12'(b));
         `CHK(g.start, 1'b0);
         rchk(`FSPG_REG_STAT, 32'h9, 32'h8);
         wb(1'b1, `FSPG_REG_STAT, 32'h8);
         wb(1'b1, `FSPG_REG_CTRL, 32'h1);
         op(FSPG_OP_WRITE, 12'(b), 12'(b));
         `CHK(g.start_halting, 1'b1);
         `CHK(halt, 1'b1);
         `CHK(page, 12'(b));
         wait_idle();
      end
   endtask : t_fuses

   // busy section: cleared once by re-enable, once by a page load
   task automatic t_rww();
      fuse <= 2'h3;
      dly <= 8'd30;
      wb(1'b1, `FSPG_REG_CFG, 32'h1);
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, `FSPG_REG_CTRL, 32'h1);
         op(FSPG_OP_ERASE, 12'hf80, 12'h100);
         `CHK({g.start, g.start_halting, halt}, 3'b100);
         rchk(`FSPG_REG_STAT, 32'h1, 32'h1);
         op(FSPG_OP_LOAD, 12'hf80, 12'hf90);
         `CHK(g.load_ok, 1'b1);
         for (int i = 0; i < 80 && done !== 1'b1; i++) @(posedge core_clk);
         rchk(`FSPG_REG_STAT, 32'h1, 32'h1);
         wb(1'b1, `FSPG_REG_CTRL, k ? 32'h1 : 32'h3);
         op(k ? FSPG_OP_PAGELOAD : FSPG_OP_LOAD, 12'hf80, 12'hf90);
         rchk(`FSPG_REG_STAT, 32'h1, 32'h0);
      end
      dly <= 8'd6;
   endtask : t_rww

   task automatic t_locks();
      wb(1'b1, `FSPG_REG_LOCK, 32'he);
      wb(1'b1, `FSPG_REG_CTRL, 32'h1);
      op(FSPG_OP_ERASE, 12'hf80, 12'h100);
      `CHK({g.start, halt}, 2'b00);
      rchk(`FSPG_REG_STAT, 32'h1, 32'h0);
      op(FSPG_OP_LOAD, 12'hf80, 12'h100);
      `CHK(g.load_ok, 1'b1);
      wb(1'b1, `FSPG_REG_LOCK, 32'hc);
      wb(1'b1, `FSPG_REG_LOCK, 32'hf);
      rchk(`FSPG_REG_LOCK, 32'hf, 32'hc);
      op(FSPG_OP_LOAD, 12'hf80, 12'h100);
      `CHK(g.load_blocked, 1'b1);
      wb(1'b1, `FSPG_REG_CFG, 32'h1);
      pc <= 12'h100;
      @(negedge core_clk);
      `CHK(irq, 1'b1);
      // chip erase only in programming mode, the sole way back to 11 short of sys_rst
      wb(1'b1, `FSPG_REG_CFG, 32'h2);
      wb(1'b1, `FSPG_REG_CTRL, 32'h8);
      rchk(`FSPG_REG_LOCK, 32'hf, 32'hf);
      wb(1'b1, `FSPG_REG_LOCK, 32'h7);
      op(FSPG_OP_LOAD, 12'h100, 12'hf90);
      `CHK(g.load_blocked, 1'b1);
      pc <= 12'hf90;
      @(negedge core_clk);
      `CHK(irq, 1'b1);
      wb(1'b1, `FSPG_REG_CTRL, 32'h1);
      op(FSPG_OP_WRITE, 12'hf80, 12'hf90);
      `CHK(g.start, 1'b1);
      wait_idle();
      wb(1'b1, `FSPG_REG_LOCK, 32'h3);
      wb(1'b1, `FSPG_REG_CTRL, 32'h1);
      op(FSPG_OP_WRITE, 12'hf80, 12'hf90);
      `CHK(g.start, 1'b0);
      op(FSPG_OP_LOAD, 12'h100, 12'h100);
      `CHK(g.load_ok, 1'b1);
   endtask : t_locks

   // reset for six cycles, then every scenario in turn
   initial begin
      {core_clk, cyc, stb, we, adr, sel, dat, fuse, mlock, pc} = '0;
      sys_rst = 1'b1;
      req = '0;
      dly = 8'd6;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_fuses();
      t_rww();
      t_locks();
      results();
   end
endmodule : tb_flash_self_program_guard
